// [logic/scu_pkg.sv]
// Shared constants and carrier types of the shading correction unit
package scu_pkg;
  localparam int PIX_W = 8;
  localparam int FAC_W = 8;
  localparam int ACC_W = 16;
  localparam int CHUNK_BYTES = 2048;
  localparam int OFF_W = 11;
  localparam int CHUNK_W = 5;
  localparam int CNT_W = 9;
  localparam int DIV_STEPS = 16;
  localparam logic [4:0] DIV_LAST = 5'h10;
  localparam logic [8:0] FAC_ONE = 9'h100;
  localparam logic [7:0] FAC_MAX = 8'hff;
  localparam logic [7:0] PIX_FULL = 8'hff;
  localparam logic [8:0] FRAMES_RST = 9'h001;
  localparam int FIFO_DEPTH = 2;

  typedef struct packed {
    logic sof;
    logic eof;
    logic [PIX_W-1:0] data;
  } scu_pix_t;

  typedef struct packed {
    logic write;
    logic [CHUNK_W-1:0] chunk;
    logic [OFF_W-1:0] off;
    logic [FAC_W-1:0] wdata;
  } scu_tbl_req_t;
endpackage

// [logic/scu_mem.sv]
// Simple dual-port memory with registered read data
`timescale 1ns/1ns
module scu_mem #(
  parameter int W = 16,
  parameter int DEPTH = 4096,
  parameter int AW = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem_q [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= mem_q[raddr];
    end
  end
endmodule

// [logic/scu_top.sv]
// Shading correction unit: reference generation, correction and table port
//
// How it works
// - Correct at full width; binning comes after.
// - Rows arrive already vertically binned.
// - Output is pixel times one plus factor/256.
// - Capture the programmed number of frames.
// - Per-pixel sum of captured frames shifted right by floor log2 of the count.
// - Brightest pixel unity; others raised to it.
// - Every factor written into reference memory.
// - Factor limited to two, darker stays under.
// - Pixels beyond generated window pass unchanged.
// - Capture paused during generation, then resumed.
// - Table moves in chunks through exchange buffer.
// - Exchange buffer chunk at most 2 kB.
// - Table kept inside or read by host.
`timescale 1ns/1ns
module scu_top #(
  parameter int MAX_PIX = 4096,
  parameter int AW = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Generation control
  input wire logic gen_start,
  input wire logic [scu_pkg::CNT_W-1:0] frame_average_count,
  output logic busy,
  output logic capture_paused,
  // Pixel input
  input wire scu_pkg::scu_pix_t in_pix,
  input wire logic in_valid,
  output logic in_ready,
  // Pixel output
  output scu_pkg::scu_pix_t out_pix,
  output logic out_valid,
  input wire logic out_ready,
  // Reference table port
  input wire scu_pkg::scu_tbl_req_t tbl_req,
  input wire logic tbl_valid,
  output logic tbl_ready,
  output logic tbl_rvalid,
  output logic [scu_pkg::FAC_W-1:0] tbl_rdata
);
  typedef enum logic [2:0] {ST_IDLE, ST_ARM, ST_ACC, ST_SCAN, ST_RD, ST_DIV, ST_WR} scu_st_t;
  scu_st_t st_q;

  logic [AW:0] pix_idx_q, cur_idx, gen_len_q, scan_idx_q, div_idx_q;
  logic [scu_pkg::CNT_W-1:0] frames_q;
  logic [3:0] shift_q;
  logic first_q;
  logic [7:0] max_q, mean, den_q;
  logic [8:0] rem_q, rem_sh;
  logic [15:0] num_q;
  logic [4:0] div_cnt_q;
  logic div_ge;
  logic [7:0] fac_wr;
  logic in_fire, acc_go, cor_go, tbl_take, scan_rd;
  logic a_v_q, a_first_q, sc_v_q, s_v_q, s_in_q;
  logic [AW:0] a_idx_q;
  logic [7:0] a_pix_q;
  scu_pkg::scu_pix_t s_pix_q, res_pix;
  logic [16:0] prod;
  logic mem_we;
  logic [AW-1:0] mem_waddr, mem_raddr;
  logic [scu_pkg::ACC_W-1:0] mem_wdata, mem_rdata;
  logic [15:0] tbl_addr;
  scu_pkg::scu_pix_t fifo_q [scu_pkg::FIFO_DEPTH];
  logic wr_ptr_q, rd_ptr_q;
  logic [1:0] cnt_q;
  logic push, pop;

  function automatic logic [3:0] log2f(input logic [8:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 1; i < 9; i++) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  assign busy = (st_q != ST_IDLE);
  assign capture_paused = busy;
  assign tbl_ready = !busy;
  assign tbl_take = tbl_valid && tbl_ready;
  assign tbl_addr = {tbl_req.chunk, tbl_req.off};
  assign in_fire = in_valid && in_ready;
  assign cur_idx = in_pix.sof ? '0 : pix_idx_q;
  assign acc_go = in_fire && (st_q == ST_ACC || (st_q == ST_ARM && in_pix.sof));
  assign cor_go = in_fire && !busy;
  assign scan_rd = (st_q == ST_SCAN) && !a_v_q && (scan_idx_q < gen_len_q);
  assign mean = 8'(mem_rdata >> shift_q);

  // Frames are swallowed while busy, so the source never stalls during generation
  always_comb begin
    if (busy) begin
      in_ready = 1'b1;
    end else begin
      in_ready = !tbl_valid && ({1'b0, cnt_q} + {2'b00, s_v_q} < 3'h2);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pix_idx_q <= '0;
    end else if (in_fire) begin
      pix_idx_q <= cur_idx + 1'b1;
    end
  end

  // Sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= ST_IDLE;
      frames_q <= scu_pkg::FRAMES_RST;
      shift_q <= '0;
      first_q <= 1'b0;
      scan_idx_q <= '0;
      div_idx_q <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (gen_start) begin
            st_q <= ST_ARM;
            frames_q <= (frame_average_count == '0) ? scu_pkg::FRAMES_RST
                                                    : frame_average_count;
            shift_q <= log2f(frame_average_count);
            first_q <= 1'b1;
          end
        end
        ST_ARM, ST_ACC: begin
          if (acc_go) begin
            st_q <= ST_ACC;
            if (in_pix.eof) begin
              first_q <= 1'b0;
              frames_q <= frames_q - 1'b1;
              if (frames_q == scu_pkg::FRAMES_RST) begin
                st_q <= ST_SCAN;
                scan_idx_q <= '0;
              end
            end
          end
        end
        ST_SCAN: begin
          if (scan_rd) begin
            scan_idx_q <= scan_idx_q + 1'b1;
          end else if (!a_v_q && !sc_v_q) begin
            st_q <= (gen_len_q == '0) ? ST_IDLE : ST_RD;
            div_idx_q <= '0;
          end
        end
        ST_RD: st_q <= ST_DIV;
        ST_DIV: begin
          if (div_cnt_q == scu_pkg::DIV_LAST) begin
            st_q <= ST_WR;
          end
        end
        ST_WR: begin
          div_idx_q <= div_idx_q + 1'b1;
          st_q <= (div_idx_q + 1'b1 == gen_len_q) ? ST_IDLE : ST_RD;
        end
      endcase
    end
  end

  // Window of the generated image; host writes can widen it
  always_ff @(posedge clk) begin
    if (rst) begin
      gen_len_q <= '0;
    end else if (acc_go && in_pix.eof && first_q) begin
      gen_len_q <= (cur_idx < (AW+1)'(MAX_PIX)) ? cur_idx + 1'b1 : (AW+1)'(MAX_PIX);
    end else if (tbl_take && tbl_req.write && tbl_addr < 16'(MAX_PIX)
                 && (AW+1)'(tbl_addr) >= gen_len_q) begin
      gen_len_q <= (AW+1)'(tbl_addr) + 1'b1;
    end
  end

  // Accumulation stage, read-modify-write one cycle apart
  always_ff @(posedge clk) begin
    if (rst) begin
      a_v_q <= 1'b0;
      a_idx_q <= '0;
      a_pix_q <= '0;
      a_first_q <= 1'b0;
    end else begin
      a_v_q <= acc_go && cur_idx < (AW+1)'(MAX_PIX);
      a_idx_q <= cur_idx;
      a_pix_q <= in_pix.data;
      a_first_q <= first_q;
    end
  end

  // Brightest mean pixel
  always_ff @(posedge clk) begin
    if (rst) begin
      sc_v_q <= 1'b0;
      max_q <= '0;
    end else begin
      sc_v_q <= scan_rd;
      if (gen_start && !busy) begin
        max_q <= '0;
      end else if (sc_v_q && mean > max_q) begin
        max_q <= mean;
      end
    end
  end

  // Restoring divider: quotient = max * 256 / mean
  assign rem_sh = {rem_q[7:0], num_q[15]};
  assign div_ge = rem_sh >= {1'b0, den_q};
  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt_q <= '0;
      den_q <= '0;
      rem_q <= '0;
      num_q <= '0;
    end else if (st_q == ST_RD) begin
      div_cnt_q <= '0;
    end else if (st_q == ST_DIV) begin
      if (div_cnt_q == '0) begin
        den_q <= mean;
        num_q <= {max_q, 8'h00};
        rem_q <= '0;
      end else begin
        rem_q <= div_ge ? rem_sh - {1'b0, den_q} : rem_sh;
        num_q <= {num_q[14:0], div_ge};
      end
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  // A zero mean yields all ones and so the limit
  assign fac_wr = (num_q[15:9] != '0) ? scu_pkg::FAC_MAX : num_q[7:0];

  always_comb begin
    mem_we = 1'b0;
    mem_waddr = tbl_addr[AW-1:0];
    mem_wdata = {8'h00, tbl_req.wdata};
    mem_raddr = cur_idx[AW-1:0];
    if (a_v_q) begin
      mem_we = 1'b1;
      mem_waddr = a_idx_q[AW-1:0];
      mem_wdata = a_first_q ? {8'h00, a_pix_q} : mem_rdata + {8'h00, a_pix_q};
    end else if (st_q == ST_WR) begin
      mem_we = 1'b1;
      mem_waddr = div_idx_q[AW-1:0];
      mem_wdata = {8'h00, fac_wr};
    end else if (tbl_take && tbl_req.write) begin
      mem_we = 1'b1;
    end
    if (st_q == ST_SCAN) begin
      mem_raddr = scan_idx_q[AW-1:0];
    end else if (st_q == ST_RD) begin
      mem_raddr = div_idx_q[AW-1:0];
    end else if (tbl_take) begin
      mem_raddr = tbl_addr[AW-1:0];
    end
  end

  scu_mem #(.W(scu_pkg::ACC_W), .DEPTH(MAX_PIX), .AW(AW)) u_mem (
    .clk(clk),
    .rst(rst),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      tbl_rvalid <= 1'b0;
    end else begin
      tbl_rvalid <= tbl_take && !tbl_req.write;
    end
  end
  assign tbl_rdata = mem_rdata[scu_pkg::FAC_W-1:0];

  // Correction stage on the full-width stream
  always_ff @(posedge clk) begin
    if (rst) begin
      s_v_q <= 1'b0;
      s_in_q <= 1'b0;
      s_pix_q <= '0;
    end else begin
      s_v_q <= cor_go;
      s_in_q <= cur_idx < gen_len_q;
      s_pix_q <= in_pix;
    end
  end

  assign prod = s_pix_q.data * ({1'b0, scu_pkg::FAC_ONE} + {9'h000, mem_rdata[7:0]});
  always_comb begin
    res_pix = s_pix_q;
    if (s_in_q) begin
      res_pix.data = prod[16] ? scu_pkg::PIX_FULL : prod[15:8];
    end
  end

  // Two-entry output buffer
  assign push = s_v_q;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_pix = fifo_q[rd_ptr_q];
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= '0;
      fifo_q[0] <= '0;
      fifo_q[1] <= '0;
    end else begin
      if (push) begin
        fifo_q[wr_ptr_q] <= res_pix;
        wr_ptr_q <= !wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= !rd_ptr_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_last_wr;
    st_q == ST_WR && div_idx_q + 1'b1 == gen_len_q;
  endsequence
  property p_busy_start;
    !busy && gen_start |=> busy [*2];
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("start not busy");
  property p_ready_after;
    s_last_wr |=> !busy && tbl_ready;
  endproperty
  a_ready_after: assert property (p_ready_after) else $error("not ready at end");
  property p_pause;
    busy |-> ##1 !push;
  endproperty
  a_pause: assert property (p_pause) else $error("output during generation");
  property p_unity;
    st_q == ST_WR && den_q == max_q && max_q != '0 |-> mem_wdata == '0;
  endproperty
  a_unity: assert property (p_unity) else $error("brightest not unity");
  property p_limit;
    st_q == ST_WR && {1'b0, den_q, 1'b0} <= {2'b00, max_q} |-> mem_wdata[7:0] == 8'hff;
  endproperty
  a_limit: assert property (p_limit) else $error("factor not limited");
  property p_pass;
    push && !s_in_q |-> res_pix.data == s_pix_q.data;
  endproperty
  a_pass: assert property (p_pass) else $error("outside window altered");
  property p_sat;
    push && s_in_q && prod[16] |-> res_pix.data == 8'hff;
  endproperty
  a_sat: assert property (p_sat) else $error("no saturation");
  sequence s_mid_eof;
    acc_go && in_pix.eof && frames_q != scu_pkg::FRAMES_RST;
  endsequence
  sequence s_last_eof;
    acc_go && in_pix.eof && frames_q == scu_pkg::FRAMES_RST;
  endsequence
  property p_frames;
    s_mid_eof |=> st_q == ST_ACC;
  endproperty
  a_frames: assert property (p_frames) else $error("frame count cut short");
  property p_frames_end;
    s_last_eof |=> st_q == ST_SCAN;
  endproperty
  a_frames_end: assert property (p_frames_end) else $error("extra frame captured");
  property p_tbl_read;
    tbl_take && !tbl_req.write |=> tbl_rvalid ##1 !tbl_rvalid || $past(tbl_take);
  endproperty
  a_tbl_read: assert property (p_tbl_read) else $error("table read answer");
  property p_fifo;
    cnt_q != 2'h2 || !push || pop;
  endproperty
  a_fifo: assert property (p_fifo) else $error("buffer overrun");
endmodule

// [bench/scu_sink.sv]
// Pixel sink standing in for the downstream stage, with random stalls
`timescale 1ns/1ns
module scu_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pixel handshake
  input wire logic out_valid,
  output logic out_ready
);
  initial out_ready = 1'b0;
  // Stall about a quarter of the cycles so the buffer fills now and then
  always @(negedge clk) begin
    out_ready <= !rst && ($urandom_range(3) != 0);
  end
endmodule

// [bench/testbench.sv]
// Self-checking bench of the shading correction unit
`timescale 1ns/1ns
module testbench;
  logic clk, rst, gen_start, busy, capture_paused, in_valid, in_ready, out_valid, out_ready;
  logic tbl_valid, tbl_ready, tbl_rvalid;
  logic [8:0] frame_average_count;
  logic [7:0] tbl_rdata;
  scu_pkg::scu_pix_t in_pix, out_pix;
  scu_pkg::scu_tbl_req_t tbl_req;
  int miscompares, checks_done, cycles;
  logic [7:0] exp_q[$];
  logic [1:0] flg_q[$];
  logic [7:0] fac[4];
  logic [7:0] pix[4];

  scu_top #(.MAX_PIX(16), .AW(4)) i_scu_top (.clk(clk), .rst(rst), .gen_start(gen_start),
    .frame_average_count(frame_average_count), .busy(busy), .capture_paused(capture_paused),
    .in_pix(in_pix), .in_valid(in_valid), .in_ready(in_ready), .out_pix(out_pix),
    .out_valid(out_valid), .out_ready(out_ready), .tbl_req(tbl_req), .tbl_valid(tbl_valid),
    .tbl_ready(tbl_ready), .tbl_rvalid(tbl_rvalid), .tbl_rdata(tbl_rdata));
  scu_sink i_scu_sink (.clk(clk), .rst(rst), .out_valid(out_valid), .out_ready(out_ready));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Expected correction, saturating at full scale
  function automatic logic [7:0] corr(input logic [7:0] d, input logic [7:0] f);
    logic [16:0] p;
    p = (17'(d) * (17'h100 + 17'(f))) >> 8;
    return (p > 17'h0ff) ? 8'hff : p[7:0];
  endfunction

  // One pixel; exp is noted only when a result is due
  task automatic send(input logic [7:0] d, input logic s, input logic e, input logic due,
                      input logic [7:0] exp);
    @(negedge clk);
    in_pix = '{sof: s, eof: e, data: d};
    in_valid = 1'b1;
    #1;
    while (in_ready !== 1'b1) begin
      @(negedge clk);
      #1;
    end
    @(posedge clk);
    if (due) begin
      exp_q.push_back(exp);
      flg_q.push_back({s, e});
    end
  endtask

  task automatic tbl(input logic wr, input logic [10:0] off, input logic [7:0] wd,
                     input logic [7:0] exp);
    int n;
    @(negedge clk);
    in_valid = 1'b0;
    tbl_req = '{write: wr, chunk: 5'h00, off: off, wdata: wd};
    tbl_valid = 1'b1;
    #1;
    check("pixel refused", 8'(in_ready), 8'h00);
    while (tbl_ready !== 1'b1) begin
      @(negedge clk);
      #1;
    end
    @(posedge clk);
    @(negedge clk);
    tbl_valid = 1'b0;
    if (!wr) begin
      n = 0;
      while (tbl_rvalid !== 1'b1 && n < 3) begin
        @(negedge clk);
        n++;
      end
      check("table answer", 8'(tbl_rvalid), 8'h01);
      check("table read", tbl_rdata, exp);
    end
  endtask

  task automatic drain();
    @(negedge clk);
    in_valid = 1'b0;
    repeat (200) if (exp_q.size() != 0) @(negedge clk);
    check("pending results", 8'(exp_q.size()), 8'h00);
  endtask

  // Scoreboard: every delivered pixel takes the oldest note
  always @(posedge clk) begin
    if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
      check("result noted", 8'(exp_q.size() != 0), 8'h01);
      if (exp_q.size() != 0) begin
        check("marks", {6'h00, out_pix.sof, out_pix.eof}, {6'h00, flg_q.pop_front()});
        check("pixel", out_pix.data, exp_q.pop_front());
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    logic [7:0] d;
    miscompares = 0;
    checks_done = 0;
    cycles = 0;
    rst = 1'b1;
    gen_start = 1'b0;
    frame_average_count = 9'h002;
    in_valid = 1'b0;
    in_pix = '0;
    tbl_valid = 1'b0;
    tbl_req = '0;
    void'($urandom(32'he615aea9));
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    // Nothing generated yet: pixels pass unchanged
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      send(d, i == 0, i == 7, 1'b1, d);
    end
    drain();
    $display("test passthrough done");
    // Host loads factors, reads them back, then full-width correction
    for (int i = 0; i < 4; i++) begin
      fac[i] = 8'($urandom);
      tbl(1'b1, 11'(i), fac[i], 8'h00);
    end
    for (int i = 0; i < 4; i++) tbl(1'b0, 11'(i), 8'h00, fac[i]);
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      send(d, i == 0, i == 5, 1'b1, (i < 4) ? corr(d, fac[i]) : d);
    end
    drain();
    $display("test loaded table done");
    // Automatic generation over four frames of a fixed scene
    // Brightest spot stays well below full scale
    pix = '{8'hc8, 8'ha0, 8'h64, 8'hc8};
    @(negedge clk);
    frame_average_count = 9'h004;
    gen_start = 1'b1;
    @(negedge clk);
    gen_start = 1'b0;
    check("busy", 8'(busy), 8'h01);
    check("capture paused", 8'(capture_paused), 8'h01);
    check("table refused", 8'(tbl_ready), 8'h00);
    // Frames alternate two below and two above, so only the mean gives the scene
    for (int f = 0; f < 4; f++) begin
      for (int i = 0; i < 4; i++) begin
        d = 8'(pix[i] + 4 * (f % 2) - 2);
        send(d, i == 0, i == 3, 1'b0, 8'h00);
      end
    end
    @(negedge clk);
    in_valid = 1'b0;
    // Status is a port here, so watching it every cycle slows nothing
    repeat (2000) if (busy !== 1'b0) @(negedge clk);
    check("busy", 8'(busy), 8'h00);
    check("capture paused", 8'(capture_paused), 8'h00);
    tbl(1'b0, 11'h000, 8'h00, 8'h00);
    tbl(1'b0, 11'h001, 8'h00, 8'h40);
    tbl(1'b0, 11'h002, 8'h00, 8'hff);
    tbl(1'b0, 11'h003, 8'h00, 8'h00);
    for (int i = 0; i < 6; i++) begin
      d = (i < 4) ? pix[i] : 8'($urandom);
      send(d, i == 0, i == 5, 1'b1, (i < 4) ? corr(d, (i == 1) ? 8'h40 :
           (i == 2) ? 8'hff : 8'h00) : d);
    end
    drain();
    $display("test generation done");
    summarize();
  end
endmodule
